// *** eeegl_pkg.sv ***
// Purpose: constants shared by the global energy-efficient-Ethernet configuration bank
// Assumes: 100 MHz core clock, byte-wide indirect register access path
// Notes:   offsets, reset values and the idle-wait step are held here
`default_nettype none

package eeegl_pkg;

	// ==========================================================
	// directly addressed registers
	localparam logic [7:0] ADDR_IND_CTRL    = 8'h6E;
	localparam logic [7:0] ADDR_IND_OFFSET  = 8'h6F;
	localparam logic [7:0] ADDR_IND_DATA    = 8'hA0;

	// ==========================================================
	// indirect control byte fields
	localparam int         TABLE_SEL_MSB    = 7;
	localparam int         TABLE_SEL_LSB    = 5;
	localparam logic [2:0] TABLE_SEL_EEE    = 3'h1;
	localparam int         SCOPE_MSB        = 3;
	localparam logic [3:0] SCOPE_GLOBAL     = 4'h0;

	// ==========================================================
	// global register byte offsets
	localparam logic [7:0] OFF_WAIT_HI      = 8'h32;
	localparam logic [7:0] OFF_WAIT_LO      = 8'h33;
	localparam logic [7:0] OFF_DIAG_HI      = 8'h34;
	localparam logic [7:0] OFF_DIAG_LO      = 8'h35;

	// ==========================================================
	// reset values
	localparam logic [7:0]  IND_CTRL_RESET  = 8'h00;
	localparam logic [7:0]  IND_OFF_RESET   = 8'h00;
	localparam logic [15:0] WAIT_RESET      = 16'h0010;
	localparam logic [11:0] DIAG_FIXED_BITS = 12'h680; // bits 15:4, read only
	localparam logic [3:0]  NEXT_PAGE_RESET = 4'hF;
	localparam int          NUM_PORTS       = 4;

	// ==========================================================
	// idle-wait step in ns and in clock cycles
	localparam int          CLOCK_PERIOD_NS = 10;
	localparam int          WAIT_STEP_NS    = 1300000;
	localparam int          WAIT_STEP_CYC   = WAIT_STEP_NS / CLOCK_PERIOD_NS;
	localparam int          STEP_CNT_W      = 24;

endpackage : eeegl_pkg

`default_nettype wire

// *** eeegl_idle_wait.sv ***
// Purpose: per-port idle-wait counter producing the low power idle request
// Assumes: i_tick is a one-cycle pulse once per wait step
// Notes:   count saturates, so very long idle periods keep the request up
`default_nettype none

module eeegl_idle_wait (
	input  wire logic        i_clock,
	input  wire logic        i_sys_rst,
	input  wire logic        i_clk_en,
	input  wire logic        i_tick,
	input  wire logic        i_enable,
	input  wire logic        i_empty,
	input  wire logic        i_push,
	input  wire logic [15:0] i_wait,
	output logic             o_lpi_req
);

	logic [16:0] count_reg;
	logic [16:0] count_next;
	logic        req_reg;
	logic        req_next;

	// ==========================================================
	// count steps while empty, restart on any frame
	always_comb begin
		count_next = count_reg;
		if (!i_enable || !i_empty || i_push) begin
			count_next = 17'h00000;
		end else if (i_tick && (count_reg != 17'h1FFFF)) begin
			count_next = count_reg + 17'h00001;
		end
		req_next = i_enable && i_empty && !i_push && (count_next > {1'b0, i_wait});
	end

	// registers
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			count_reg <= 17'h00000;
			req_reg   <= 1'b0;
		end else if (i_clk_en) begin
			count_reg <= count_next;
			req_reg   <= req_next;
		end
	end

	assign o_lpi_req = req_reg;

endmodule : eeegl_idle_wait

`default_nettype wire

// *** eeegl_global_cfg.sv ***
// Purpose: global energy-efficient-Ethernet configuration bank behind the indirect path
// Assumes: byte register port synchronous to i_clock, one access per strobe cycle
// Notes:   read data appears one cycle after the read strobe, with o_reg_rvalid
`default_nettype none

module eeegl_global_cfg #(
	parameter int WAIT_STEP_CYCLES = eeegl_pkg::WAIT_STEP_CYC
) (
	input  wire logic        i_clock,
	input  wire logic        i_sys_rst,
	input  wire logic        i_clk_en,
	input  wire logic [7:0]  i_reg_addr,
	input  wire logic [7:0]  i_reg_wdata,
	input  wire logic        i_reg_wr,
	input  wire logic        i_reg_rd,
	output logic      [7:0]  o_reg_rdata,
	output logic             o_reg_rvalid,
	input  wire logic [3:0]  i_eee_100_en,
	input  wire logic [3:0]  i_txq_empty,
	input  wire logic [3:0]  i_txq_push,
	output logic      [3:0]  o_lpi_req,
	output logic      [15:0] o_wait_time,
	output logic      [3:0]  o_next_page_en
);

	// ==========================================================
	// state
	logic [7:0]  ind_ctrl_reg;
	logic [7:0]  ind_ctrl_next;
	logic [7:0]  ind_off_reg;
	logic [7:0]  ind_off_next;
	logic [15:0] wait_reg;
	logic [15:0] wait_next;
	logic [3:0]  next_page_reg;
	logic [3:0]  next_page_next;
	logic [7:0]  rdata_reg;
	logic [7:0]  rdata_next;
	logic        rvalid_reg;
	logic        rvalid_next;
	logic [eeegl_pkg::STEP_CNT_W-1:0] step_cnt_reg;
	logic [eeegl_pkg::STEP_CNT_W-1:0] step_cnt_next;
	logic        tick_reg;
	logic        tick_next;

	// decode helpers
	logic        space_hit;
	logic        data_sel;
	logic [7:0]  ind_rbyte;
	logic [15:0] diag_value;
	logic [eeegl_pkg::STEP_CNT_W-1:0] step_last;

	// ==========================================================
	// indirect decode
	// only the EEE table with the global scope reaches this bank
	assign space_hit = (ind_ctrl_reg[eeegl_pkg::TABLE_SEL_MSB:eeegl_pkg::TABLE_SEL_LSB]
			== eeegl_pkg::TABLE_SEL_EEE)
		&& (ind_ctrl_reg[eeegl_pkg::SCOPE_MSB:0] == eeegl_pkg::SCOPE_GLOBAL);
	assign data_sel  = (i_reg_addr == eeegl_pkg::ADDR_IND_DATA);

	// full view of the diagnostic register, reserved bits fixed
	assign diag_value = {eeegl_pkg::DIAG_FIXED_BITS, next_page_reg};

	// byte picked by the indirect offset
	always_comb begin
		ind_rbyte = 8'h00;
		if (space_hit) begin
			unique case (ind_off_reg)
				eeegl_pkg::OFF_WAIT_HI: begin
					ind_rbyte = wait_reg[15:8];
				end
				eeegl_pkg::OFF_WAIT_LO: begin
					ind_rbyte = wait_reg[7:0];
				end
				eeegl_pkg::OFF_DIAG_HI: begin
					ind_rbyte = diag_value[15:8];
				end
				eeegl_pkg::OFF_DIAG_LO: begin
					ind_rbyte = diag_value[7:0];
				end
				default: begin
					ind_rbyte = 8'h00; // other offsets read as zero
				end
			endcase
		end
	end

	// ==========================================================
	// register writes
	always_comb begin
		ind_ctrl_next  = ind_ctrl_reg;
		ind_off_next   = ind_off_reg;
		wait_next      = wait_reg;
		next_page_next = next_page_reg;
		if (i_reg_wr) begin
			if (i_reg_addr == eeegl_pkg::ADDR_IND_CTRL) begin
				ind_ctrl_next = i_reg_wdata;
			end
			if (i_reg_addr == eeegl_pkg::ADDR_IND_OFFSET) begin
				ind_off_next = i_reg_wdata;
			end
			if (data_sel && space_hit) begin
				if (ind_off_reg == eeegl_pkg::OFF_WAIT_HI) begin
					wait_next[15:8] = i_reg_wdata;
				end
				if (ind_off_reg == eeegl_pkg::OFF_WAIT_LO) begin
					wait_next[7:0] = i_reg_wdata;
				end
				if (ind_off_reg == eeegl_pkg::OFF_DIAG_LO) begin
					next_page_next = i_reg_wdata[3:0];
				end
			end
		end
	end

	// configuration registers
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			ind_ctrl_reg  <= eeegl_pkg::IND_CTRL_RESET;
			ind_off_reg   <= eeegl_pkg::IND_OFF_RESET;
			wait_reg      <= eeegl_pkg::WAIT_RESET;
			next_page_reg <= eeegl_pkg::NEXT_PAGE_RESET;
		end else if (i_clk_en) begin
			ind_ctrl_reg  <= ind_ctrl_next;
			ind_off_reg   <= ind_off_next;
			wait_reg      <= wait_next;
			next_page_reg <= next_page_next;
		end
	end

	// ==========================================================
	// register reads
	// direct registers read back, the data byte returns the addressed byte
	always_comb begin
		rdata_next  = rdata_reg;
		rvalid_next = 1'b0;
		if (i_reg_rd) begin
			rvalid_next = 1'b1;
			unique case (i_reg_addr)
				eeegl_pkg::ADDR_IND_CTRL: begin
					rdata_next = ind_ctrl_reg;
				end
				eeegl_pkg::ADDR_IND_OFFSET: begin
					rdata_next = ind_off_reg;
				end
				eeegl_pkg::ADDR_IND_DATA: begin
					rdata_next = ind_rbyte;
				end
				default: begin
					rdata_next = 8'h00; // unmapped address
				end
			endcase
		end
	end

	// read data registers
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			rdata_reg  <= 8'h00;
			rvalid_reg <= 1'b0;
		end else if (i_clk_en) begin
			rdata_reg  <= rdata_next;
			rvalid_reg <= rvalid_next;
		end
	end

	// ==========================================================
	// wait step prescaler
	// one shared tick per 1.3 ms step serves all ports
	assign step_last = eeegl_pkg::STEP_CNT_W'(WAIT_STEP_CYCLES - 1);

	always_comb begin
		step_cnt_next = step_cnt_reg + {{(eeegl_pkg::STEP_CNT_W-1){1'b0}}, 1'b1};
		tick_next     = 1'b0;
		if (step_cnt_reg >= step_last) begin
			step_cnt_next = '0;
			tick_next     = 1'b1;
		end
	end

	// prescaler registers
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			step_cnt_reg <= '0;
			tick_reg     <= 1'b0;
		end else if (i_clk_en) begin
			step_cnt_reg <= step_cnt_next;
			tick_reg     <= tick_next;
		end
	end

	// ==========================================================
	// per-port idle-wait counters
	// every port sees the same global wait time
	genvar port_idx;
	generate
		for (port_idx = 0; port_idx < eeegl_pkg::NUM_PORTS; port_idx++) begin : g_port
			eeegl_idle_wait u_idle_wait (
				.i_clock   (i_clock),
				.i_sys_rst (i_sys_rst),
				.i_clk_en  (i_clk_en),
				.i_tick    (tick_reg),
				.i_enable  (i_eee_100_en[port_idx]),
				.i_empty   (i_txq_empty[port_idx]),
				.i_push    (i_txq_push[port_idx]),
				.i_wait    (wait_reg),
				.o_lpi_req (o_lpi_req[port_idx])
			);
		end
	endgenerate

	// ==========================================================
	// outputs
	assign o_reg_rdata    = rdata_reg;
	assign o_reg_rvalid   = rvalid_reg;
	assign o_wait_time    = wait_reg;
	assign o_next_page_en = next_page_reg;

endmodule : eeegl_global_cfg

`default_nettype wire

// *** eeegl_checker.sv ***
// Purpose: port assertions for the global eee configuration bank
// Assumes: one clock domain, synchronous active high reset
// Notes:   bound to every eeegl_global_cfg instance
`default_nettype none

module eeegl_checker #(
	parameter int WAIT_STEP_CYCLES = 4
) (
	input wire logic        i_clock,
	input wire logic        i_sys_rst,
	input wire logic        i_clk_en,
	input wire logic [7:0]  i_reg_addr,
	input wire logic [7:0]  i_reg_wdata,
	input wire logic        i_reg_wr,
	input wire logic        i_reg_rd,
	input wire logic [7:0]  o_reg_rdata,
	input wire logic        o_reg_rvalid,
	input wire logic [3:0]  i_eee_100_en,
	input wire logic [3:0]  i_txq_empty,
	input wire logic [3:0]  i_txq_push,
	input wire logic [3:0]  o_lpi_req,
	input wire logic [15:0] o_wait_time,
	input wire logic [3:0]  o_next_page_en
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_sys_rst);
	logic dwr;

	// an enabled write strobe to the data byte
	assign dwr = i_clk_en && i_reg_wr && (i_reg_addr == eeegl_pkg::ADDR_IND_DATA);

	// ==========================================================
	// register port
	sequence s_rd; i_clk_en && i_reg_rd; endsequence
	sequence s_ans; o_reg_rvalid; endsequence
	property p_rd; s_rd |=> s_ans; endproperty
	a_rd: assert property (p_rd) else $error("read not answered");
	property p_nrd; i_clk_en && !i_reg_rd |=> !o_reg_rvalid; endproperty
	a_nrd: assert property (p_nrd) else $error("stray read valid");
	// a reset edge may also move the outputs back to their reset values
	property p_hold; $changed(o_reg_rdata) |-> o_reg_rvalid || $past(i_sys_rst); endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	property p_wt; $changed(o_wait_time) |-> $past(dwr) || $past(i_sys_rst); endproperty
	a_wt: assert property (p_wt) else $error("wait time moved");
	property p_np; $changed(o_next_page_en) |-> $past(dwr) || $past(i_sys_rst); endproperty
	a_np: assert property (p_np) else $error("next page moved");
	// clock enable low holds the wait time, requests, read valid and next page outputs
	property p_frz;
		!i_clk_en && !i_sys_rst |=> $stable(o_wait_time) && $stable(o_lpi_req)
			&& $stable(o_reg_rvalid) && $stable(o_next_page_en);
	endproperty
	a_frz: assert property (p_frz) else $error("state moved while frozen");

	// ==========================================================
	// idle requests
	property p_en; i_clk_en |=> (o_lpi_req & ~$past(i_eee_100_en)) == 4'h0; endproperty
	a_en: assert property (p_en) else $error("request while off");
	property p_push; i_clk_en |=> (o_lpi_req & $past(i_txq_push)) == 4'h0; endproperty
	a_push: assert property (p_push) else $error("request after push");
	property p_emp; i_clk_en |=> (o_lpi_req & ~$past(i_txq_empty)) == 4'h0; endproperty
	a_emp: assert property (p_emp) else $error("request while busy");
endmodule : eeegl_checker

bind eeegl_global_cfg eeegl_checker #(.WAIT_STEP_CYCLES(WAIT_STEP_CYCLES)) u_chk (
	.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en),
	.i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
	.i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
	.i_eee_100_en(i_eee_100_en), .i_txq_empty(i_txq_empty), .i_txq_push(i_txq_push),
	.o_lpi_req(o_lpi_req), .o_wait_time(o_wait_time), .o_next_page_en(o_next_page_en));

`default_nettype wire

// *** eeegl_global_cfg_bench.sv ***
// Purpose: self-checking bench for the global eee configuration bank
// Assumes: short wait step so idle requests show quickly
// Notes:   random bytes come from an lfsr seeded with 98
`default_nettype none

module eeegl_global_cfg_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int STEP = 4;
	logic        clk;
	logic        rst = 1'h1;
	logic        cen = 1'h1;
	logic [7:0]  addr = 8'h00;
	logic [7:0]  wdata = 8'h00;
	logic        wr = 1'h0;
	logic        rd = 1'h0;
	logic [3:0]  eee = 4'hF;
	logic [3:0]  empty = 4'h0;
	logic [3:0]  push = 4'h0;
	logic [7:0]  rdata;
	logic        rvalid;
	logic [3:0]  lpi;
	logic [15:0] wt;
	logic [3:0]  np;
	logic [7:0]  s = 8'h62;
	logic [15:0] v;
	logic [7:0]  bad [3] = '{8'h40, 8'hE0, 8'h21};
	int          error_cnt = 0;
	int          samples_checked = 0;
	int          n;
	int          w;

	eeegl_global_cfg #(.WAIT_STEP_CYCLES(STEP)) dut (
		.i_clock(clk), .i_sys_rst(rst), .i_clk_en(cen), .i_reg_addr(addr),
		.i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata),
		.o_reg_rvalid(rvalid), .i_eee_100_en(eee), .i_txq_empty(empty),
		.i_txq_push(push), .o_lpi_req(lpi), .o_wait_time(wt), .o_next_page_en(np));

	// ==========================================================
	// helpers
	function automatic logic [7:0] lfsr(input logic [7:0] x);
		return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
	endfunction : lfsr
	// request must come later than the wait, within one step more
	function automatic logic ok_delay(input int cyc, input int wait_val);
		return (cyc > wait_val * STEP) && (cyc <= (wait_val + 1) * STEP + 1);
	endfunction : ok_delay
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic report_and_stop();
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : report_and_stop
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		addr = a;
		wdata = d;
		wr = 1'h1;
		@(posedge clk);
		#1 wr = 1'h0;
		@(posedge clk);
		#1;
	endtask : wreg
	task automatic rreg(input logic [7:0] a, input logic [7:0] e);
		addr = a;
		rd = 1'h1;
		@(posedge clk);
		#1 rd = 1'h0;
		chk(rvalid, 1'h1);
		chk(rdata, e);
		@(posedge clk);
		#1;
	endtask : rreg
	task automatic iwr(input logic [7:0] o, input logic [7:0] d);
		wreg(8'h6E, 8'h20);
		wreg(8'h6F, o);
		wreg(8'hA0, d);
	endtask : iwr
	task automatic ird(input logic [7:0] o, input logic [7:0] e);
		wreg(8'h6E, 8'h20);
		wreg(8'h6F, o);
		rreg(8'hA0, e);
	endtask : ird

	// clock
	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end

	// ==========================================================
	// main sequence
	initial begin
		repeat (10) @(posedge clk);
		#1 rst = 1'h0;
		chk(wt, 16'h0010);
		chk(np, 4'hF);
		ird(8'h32, 8'h00);
		ird(8'h33, 8'h10);
		ird(8'h34, 8'h68);
		ird(8'h35, 8'h0F);
		// random bytes through both registers
		for (int k = 0; k < 6; k++) begin
			s = lfsr(s);
			v[15:8] = s;
			s = lfsr(s);
			v[7:0] = s;
			iwr(8'h32, v[15:8]);
			iwr(8'h33, v[7:0]);
			chk(wt, v);
			ird(8'h32, v[15:8]);
			iwr(8'h35, v[7:0]);
			iwr(8'h34, v[15:8]);
			chk(np, v[3:0]);
			ird(8'h35, {4'h0, v[3:0]});
			ird(8'h34, 8'h68);
		end
		// clock enable low freezes the bank, no write lands
		cen = 1'h0;
		iwr(8'h33, ~v[7:0]);
		cen = 1'h1;
		chk(wt, v);
		ird(8'h33, v[7:0]);
		// wrong table or per-port scope leaves the bank alone
		for (int k = 0; k < 3; k++) begin
			wreg(8'h6E, bad[k]);
			wreg(8'h6F, 8'h33);
			wreg(8'hA0, 8'h5A);
			rreg(8'hA0, 8'h00);
		end
		chk(wt, v);
		ird(8'h36, 8'h00);
		rreg(8'h6F, 8'h36);
		rreg(8'h10, 8'h00);
		// idle requests with a shared wait; port 2 off, port 3 busy
		for (int k = 0; k < 2; k++) begin
			w = k * 3;
			iwr(8'h32, 8'h00);
			iwr(8'h33, w[7:0]);
			eee = 4'hB;
			empty = 4'h7;
			n = 0;
			while (lpi[0] !== 1'h1 && n < 200) begin
				@(posedge clk);
				#1 n++;
			end
			if (n >= 200) begin
				error_cnt++;
				report_and_stop();
			end
			chk(ok_delay(n, w), 1'h1);
			chk(lpi, 4'h3);
			push = 4'h2;
			@(posedge clk);
			#1 push = 4'h0;
			chk(lpi, 4'h1);
			empty = 4'h0;
			@(posedge clk);
			#1 chk(lpi, 4'h0);
		end
		// reset again in mid-run, with read data standing
		rreg(8'h6E, 8'h20);
		rst = 1'h1;
		@(posedge clk);
		#1 rst = 1'h0;
		chk(wt, 16'h0010);
		chk(np, 4'hF);
		chk(rdata, 8'h00);
		chk(rvalid, 1'h0);
		rreg(8'h6E, 8'h00);
		report_and_stop();
	end
endmodule : eeegl_global_cfg_bench

`default_nettype wire
